// *** hw/clk_div_pkg.sv ***
// Purpose: shared constants and carriers for the odd-ratio clock divider
// Assumes: the divided input clock arrives as a sampled level pair
// Notes: half-cycle counts index the input clock edges within one output period
`default_nettype none
package clk_div_pkg;
	localparam int CNT_W = 4;
	localparam logic [3:0] RATIO_LO = 4'h3; // selected when the select pin is low
	localparam logic [3:0] RATIO_HI = 4'h5; // selected when high or left open
	localparam logic [3:0] CNT_IDLE = 4'hF; // index before the first rising edge
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;

	typedef struct packed {
		logic p;
		logic n;
	} diff_pair_t;

	typedef enum logic [4:0] {
		GATE_OFF = 5'b0_0001,
		GATE_WAIT_RISE = 5'b0_0010,
		GATE_WAIT_FALL = 5'b0_0100,
		GATE_ON = 5'b0_1000,
		GATE_DRAIN = 5'b1_0000
	} gate_state_t;
endpackage
`default_nettype wire

// *** hw/half_edge_phase.sv ***
// Purpose: counts both edges of the sampled input clock within one output period
// Assumes: in_level is synchronous to clk and holds each half cycle for at least one clk
// Notes: a rising edge at the end of a period realigns the count to zero
`timescale 1ns/10ps
`default_nettype none
module half_edge_phase #(
	parameter int CNT_W = clk_div_pkg::CNT_W
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clear,
	input wire logic in_level,
	input wire logic [3:0] ratio,
	output logic rise_ev,
	output logic fall_ev,
	output logic [CNT_W-1:0] cnt,
	output logic [CNT_W-1:0] next_cnt
);
	logic prev_level;
	logic [CNT_W-1:0] last_idx;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		rise_ev = in_level & ~prev_level;
		fall_ev = ~in_level & prev_level;
		last_idx = CNT_W'({ratio, 1'b0} - 5'd1);
		next_cnt = cnt;
		// both edges advance the count, so odd ratios split at a half cycle
		if (rise_ev) begin // RL5
			if (cnt >= last_idx - CNT_W'(1))
				next_cnt = CNT_W'(clk_div_pkg::CNT_ZERO);
			else
				next_cnt = cnt + CNT_W'(clk_div_pkg::CNT_ONE);
		end else if (fall_ev && cnt < last_idx) begin // RL5
			next_cnt = cnt + CNT_W'(clk_div_pkg::CNT_ONE);
		end
		if (clear)
			next_cnt = CNT_W'(clk_div_pkg::CNT_IDLE);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prev_level <= 1'b0;
			cnt <= CNT_W'(clk_div_pkg::CNT_IDLE);
		end else begin
			prev_level <= in_level;
			cnt <= next_cnt;
		end
	end
endmodule // half_edge_phase
`default_nettype wire

// *** hw/odd_clock_divider.sv ***
// Purpose: divide the sampled input clock by three or five with a glitch-free enable
// Assumes: all pins sampled on clk; an undriven enable or select pin is flagged by its *_open input
// Notes: output pulses only ever start at period start and run full width unless master reset cuts them or the ratio changes mid-pulse
// Summary of operation
// [RL1] enable gates the divided output synchronously: high passes it, low stops it
// [RL2] on enable rising, output resumes after one input rising then one falling edge
// [RL3] on enable falling, stop after an input rising edge and an output falling edge
// [RL4] a started output pulse always completes full width before the output rests
// [RL5] both input clock edges drive the output waveform
// [RL6] divide by three: output falls on the second input cycle's falling edge
// [RL7] divide by five: output falls on the third input cycle's falling edge
// [RL8] an undriven enable reads as high
// [RL9] select low divides by three, select high divides by five
// [RL10] an undriven select reads as high, giving divide by five
// [RL11] master reset low forces true low, complement high; disabled output rests the same
`timescale 1ns/10ps
`default_nettype none
module odd_clock_divider #(
	parameter int CNT_W = clk_div_pkg::CNT_W
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire clk_div_pkg::diff_pair_t in_clk,
	input wire logic en,
	input wire logic en_open,
	input wire logic div_sel,
	input wire logic div_sel_open,
	input wire logic master_reset_n,
	output clk_div_pkg::diff_pair_t out_clk
);
	logic en_eff;
	logic ratio_hi;
	logic [3:0] ratio;
	logic in_level;
	logic rise_ev;
	logic fall_ev;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic q;
	logic next_q;
	logic high_next;
	logic start_next;
	clk_div_pkg::gate_state_t state;
	clk_div_pkg::gate_state_t next_state;

	////////////////////////////////////////////////////////////////////////
	// pin decode; pull-ups modelled by the open flags
	always_comb begin
		en_eff = en | en_open; // RL8
		ratio_hi = div_sel | div_sel_open; // RL10
		ratio = ratio_hi ? clk_div_pkg::RATIO_HI : clk_div_pkg::RATIO_LO; // RL9
		// a pair that is not clearly high reads low, so a stuck pair idles the divider
		in_level = in_clk.p & ~in_clk.n;
	end

	half_edge_phase #(.CNT_W(CNT_W)) u_phase (
		.clk(clk),
		.sys_rst(sys_rst),
		.clear(~master_reset_n),
		.in_level(in_level),
		.ratio(ratio),
		.rise_ev(rise_ev),
		.fall_ev(fall_ev),
		.cnt(cnt),
		.next_cnt(next_cnt)
	);

	////////////////////////////////////////////////////////////////////////
	// enable gate
	always_comb begin
		next_state = state;
		case (state)
			clk_div_pkg::GATE_OFF: begin
				if (en_eff)
					next_state = clk_div_pkg::GATE_WAIT_RISE;
			end
			clk_div_pkg::GATE_WAIT_RISE: begin
				if (!en_eff)
					next_state = clk_div_pkg::GATE_OFF;
				else if (rise_ev)
					next_state = clk_div_pkg::GATE_WAIT_FALL; // RL2
			end
			clk_div_pkg::GATE_WAIT_FALL: begin
				if (!en_eff)
					next_state = clk_div_pkg::GATE_OFF;
				else if (fall_ev)
					next_state = clk_div_pkg::GATE_ON; // RL2
			end
			clk_div_pkg::GATE_ON: begin
				if (!en_eff && rise_ev)
					next_state = clk_div_pkg::GATE_DRAIN; // RL3
			end
			clk_div_pkg::GATE_DRAIN: begin
				// wait for the output falling edge, never cut the pulse
				// reads high_next, not next_q, so gate and output logic form no loop
				if (!(q && high_next))
					next_state = clk_div_pkg::GATE_OFF; // RL3 RL4
			end
			default: next_state = clk_div_pkg::GATE_OFF;
		endcase
		if (!master_reset_n)
			next_state = clk_div_pkg::GATE_OFF; // RL11
	end

	////////////////////////////////////////////////////////////////////////
	// output shaping: a pulse starts only at index zero and holds for ratio half cycles
	always_comb begin
		high_next = next_cnt < CNT_W'(ratio); // RL6 RL7
		start_next = rise_ev && next_cnt == CNT_W'(clk_div_pkg::CNT_ZERO);
		next_q = high_next & (q | (start_next & next_state == clk_div_pkg::GATE_ON)); // RL1 RL4
		if (!master_reset_n)
			next_q = 1'b0; // RL11
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= clk_div_pkg::GATE_OFF;
			q <= 1'b0;
		end else begin
			state <= next_state;
			q <= next_q;
		end
	end

	assign out_clk.p = q;
	assign out_clk.n = ~q; // RL11

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_reset_forces_low;
		!master_reset_n |=> !out_clk.p && out_clk.n && state == clk_div_pkg::GATE_OFF;
	endproperty
	a_reset_forces_low: assert property (p_reset_forces_low) // RL11
		else $error("reset did not park output");

	property p_off_rests_low;
		state == clk_div_pkg::GATE_OFF |-> !q && out_clk.n;
	endproperty
	a_off_rests_low: assert property (p_off_rests_low) // RL11
		else $error("disabled output not at rest");

	property p_enable_order;
		(state == clk_div_pkg::GATE_ON && $past(state) != clk_div_pkg::GATE_ON)
			|-> $past(fall_ev) && $past(state, 2) != clk_div_pkg::GATE_OFF;
	endproperty
	a_enable_order: assert property (p_enable_order) // RL2
		else $error("enabled without rise then fall");

	property p_disable_on_rise;
		(state == clk_div_pkg::GATE_DRAIN && $past(state) == clk_div_pkg::GATE_ON)
			|-> $past(rise_ev) && !$past(en_eff);
	endproperty
	a_disable_on_rise: assert property (p_disable_on_rise) // RL3
		else $error("drain without input rise");

	property p_pulse_starts_aligned;
		$rose(q) |-> cnt == CNT_W'(clk_div_pkg::CNT_ZERO) && $past(state) == clk_div_pkg::GATE_ON;
	endproperty
	a_pulse_starts_aligned: assert property (p_pulse_starts_aligned) // RL1
		else $error("runt pulse start");

	property p_no_truncation;
		$fell(q) && master_reset_n && $past(master_reset_n) && $stable(ratio)
			|-> cnt == CNT_W'(ratio);
	endproperty
	a_no_truncation: assert property (p_no_truncation) else $error("pulse cut short"); // RL4

	property p_div3_fall;
		$fell(q) && master_reset_n && $past(master_reset_n) && !ratio_hi && !$past(ratio_hi)
			|-> $past(fall_ev) && cnt == CNT_W'(clk_div_pkg::RATIO_LO);
	endproperty
	a_div3_fall: assert property (p_div3_fall) // RL6 RL9
		else $error("divide by three fall misplaced");

	property p_div5_fall;
		$fell(q) && master_reset_n && $past(master_reset_n) && ratio_hi && $past(ratio_hi)
			|-> $past(fall_ev) && cnt == CNT_W'(clk_div_pkg::RATIO_HI);
	endproperty
	a_div5_fall: assert property (p_div5_fall) // RL7 RL10
		else $error("divide by five fall misplaced");

	property p_edges_drive_count;
		master_reset_n && $past(master_reset_n) && $changed(cnt)
			|-> $past(rise_ev) || $past(fall_ev);
	endproperty
	a_edges_drive_count: assert property (p_edges_drive_count) // RL5
		else $error("count moved without edge");

	property p_open_enable;
		en_open && master_reset_n && state == clk_div_pkg::GATE_OFF
			|=> state == clk_div_pkg::GATE_WAIT_RISE || !master_reset_n;
	endproperty
	a_open_enable: assert property (p_open_enable) else $error("open enable not read high"); // RL8

	////////////////////////////////////////////////////////////////////////
	// gate moves checked one edge after their cause, pin decode in the same cycle
	property p_wait_abort;
		(state == clk_div_pkg::GATE_WAIT_RISE || state == clk_div_pkg::GATE_WAIT_FALL)
			&& !en_eff |=> state == clk_div_pkg::GATE_OFF;
	endproperty
	a_wait_abort: assert property (p_wait_abort) // RL1
		else $error("enable drop while waiting not honoured");

	property p_off_holds;
		state == clk_div_pkg::GATE_OFF && !en_eff |=> state == clk_div_pkg::GATE_OFF;
	endproperty
	a_off_holds: assert property (p_off_holds) // RL1
		else $error("gate left rest without enable");

	property p_on_holds;
		state == clk_div_pkg::GATE_ON && master_reset_n && !(rise_ev && !en_eff)
			|=> state == clk_div_pkg::GATE_ON;
	endproperty
	a_on_holds: assert property (p_on_holds) // RL3
		else $error("gate left on without input rise");

	property p_drain_exit;
		state == clk_div_pkg::GATE_DRAIN && !q |=> state == clk_div_pkg::GATE_OFF;
	endproperty
	a_drain_exit: assert property (p_drain_exit) // RL4
		else $error("drain did not end after output fall");

	// each input half cycle lasts one clk or more, so a pulse spans three clks at least
	property p_pulse_min;
		($rose(q) && master_reset_n) ##1 master_reset_n |=> q;
	endproperty
	a_pulse_min: assert property (p_pulse_min) // RL4
		else $error("output pulse shorter than three half cycles");

	property p_sel_five;
		(div_sel || div_sel_open) |-> ratio == clk_div_pkg::RATIO_HI;
	endproperty
	a_sel_five: assert property (p_sel_five) // RL9 RL10
		else $error("select high or open did not pick five");

	property p_sel_three;
		(!div_sel && !div_sel_open) |-> ratio == clk_div_pkg::RATIO_LO;
	endproperty
	a_sel_three: assert property (p_sel_three) // RL9
		else $error("select low did not pick three");

	c_div3_pulse: cover property (!ratio_hi && $fell(q));
	c_div5_pulse: cover property (ratio_hi && $fell(q));
	c_drain_full: cover property (state == clk_div_pkg::GATE_DRAIN && q ##1 !q);
	c_reenable: cover property ($rose(state == clk_div_pkg::GATE_ON));
	c_open_start: cover property (en_open && !en && state == clk_div_pkg::GATE_WAIT_RISE);
endmodule // odd_clock_divider
`default_nettype wire

// *** tb/clock_source.sv ***
// Purpose: behavioural source of the divided input clock pair
// Assumes: half is the input half period in clk cycles, at least one
// Notes: stopped source rests low, so a stop while high ends in a falling edge
`timescale 1ns/10ps
`default_nettype none
module clock_source (
	input wire logic clk,
	input wire logic run,
	input wire logic [1:0] half,
	output var clk_div_pkg::diff_pair_t in_clk
);
	int cnt = 0;
	logic lvl = 1'h0;
	initial in_clk = 2'h1;
	always @(posedge clk) begin
		if (!run) begin
			cnt = 0;
			lvl = 1'h0;
		end else if (cnt + 1 >= half) begin
			cnt = 0;
			lvl = ~lvl;
		end else begin
			cnt = cnt + 1;
		end
		in_clk <= #1 '{p: lvl, n: ~lvl};
	end
endmodule // clock_source
`default_nettype wire

// *** tb/tb_div3_div5_clock_divider.sv ***
// Purpose: self-checking bench for the odd-ratio clock divider
// Assumes: ratio changes only while the output is drained and idle
// Notes: a cycle model built from the edge rules is compared every clk
`timescale 1ns/10ps
`default_nettype none
module tb_div3_div5_clock_divider;
	logic clk, sys_rst, en, en_open, div_sel, div_sel_open, master_reset_n, run;
	logic [1:0] half;
	clk_div_pkg::diff_pair_t in_clk, out_clk;
	int errors, cmp_count, cyc, mcnt, st, nn, i;
	int unsigned seed;
	logic mq, prv, lv, r, f, e, nq, s, ps;
	odd_clock_divider u_odd_clock_divider (.clk(clk), .sys_rst(sys_rst), .in_clk(in_clk),
		.en(en), .en_open(en_open), .div_sel(div_sel), .div_sel_open(div_sel_open),
		.master_reset_n(master_reset_n), .out_clk(out_clk));
	clock_source u_clock_source (.clk(clk), .run(run), .half(half), .in_clk(in_clk));
	always #5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	// reference model; states 0 off, 1 wait rise, 2 wait fall, 3 on, 4 drain
	always @(posedge clk) begin
		lv = in_clk.p & ~in_clk.n;
		r = lv & ~prv;
		f = ~lv & prv;
		prv = lv;
		nn = (div_sel | div_sel_open) ? 5 : 3;
		e = en | en_open;
		if (sys_rst || !master_reset_n) begin
			mq = 1'h0;
			st = 0;
			mcnt = 15;
		end else begin
			nq = mq;
			if (r)
				mcnt = (mcnt == 15 || mcnt >= 2 * nn - 2) ? 0 : mcnt + 1;
			else if (f && mcnt != 15)
				mcnt = mcnt + 1;
			// a start needs the gate to stay on, so a disabling rise starts nothing
			if (r && mcnt == 0 && st == 3 && e)
				nq = 1'h1;
			if (f && mcnt == nn)
				nq = 1'h0;
			case (st)
				0: if (e) st = 1;
				1: st = !e ? 0 : r ? 2 : 1;
				2: st = !e ? 0 : f ? 3 : 2;
				3: if (!e && r) st = 4;
				4: if (!nq) st = 0;
			endcase
			mq = nq;
		end
		cyc++;
		if (cyc >= 20000) begin
			errors++;
			results();
		end
	end
	always @(negedge clk) if (cyc > 0) chk_out(out_clk, mq);
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk_out(input clk_div_pkg::diff_pair_t got, input logic q);
		cmp_count++;
		if (got !== {q, ~q}) begin
			errors++;
			$display("MISMATCH t=%0t out=%b expected q=%b", $time, got, q);
		end
	endtask
	task automatic go(input logic e_i, eo, s_i, so, input logic [1:0] h, input int n);
		@(posedge clk);
		#1;
		en = e_i;
		en_open = eo;
		div_sel = s_i;
		div_sel_open = so;
		half = h;
		run = 1'h1;
		repeat (n) @(posedge clk);
	endtask
	task automatic results;
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{clk, en, en_open, div_sel, div_sel_open, run, prv, mq} = 8'h00;
		sys_rst = 1'h1;
		master_reset_n = 1'h1;
		half = 2'h2;
		seed = $urandom(48942);
		repeat (6) @(posedge clk);
		#1 sys_rst = 1'h0;
		go(0, 0, 0, 0, 2, 60);
		go(1, 0, 0, 0, 2, 80);
		go(0, 0, 0, 0, 2, 40);
		go(0, 0, 1, 0, 1, 20);
		go(1, 0, 1, 0, 1, 80);
		go(0, 1, 1, 0, 3, 80);
		go(0, 1, 0, 1, 3, 80);
		ps = 1'h1; // the open select step leaves divide by five in effect
		for (i = 0; i < 30; i++) begin
			s = 1'($urandom % 2);
			go(0, 0, ps, 0, 2'(1 + $urandom % 3), 40);
			ps = s;
			repeat (4) go(1'($urandom % 2), $urandom % 4 == 0, s, 0, half,
				1 + $urandom % 25);
		end
		go(1, 0, ps, 0, 2, 7);
		// stop the source first so no input edge meets the reset edge
		#1 run = 1'h0;
		repeat (3) @(posedge clk);
		#1 master_reset_n = 1'h0;
		repeat (3) @(posedge clk);
		#1 master_reset_n = 1'h1;
		go(1, 0, 0, 0, 2, 60);
		results();
	end
endmodule // tb_div3_div5_clock_divider
`default_nettype wire
